// File: logic/fpp_ctrl.sv
// fuse prom programmer: reads, programs and verifies a 2048 x 4 fuse prom
// assumes the pin drivers turn cs_hv_en into the gating level on the chip
// select and supply_en/supply_sel into the programming supply on one output
//
// Behaviour
// RULE1: the prom holds 2048 words of 4 bits, each picked by an 11-bit address.
// RULE2: with chip select low the outputs show the word at the applied address.
// RULE3: with chip select high all four outputs float, whatever the address.
// RULE4: a blank bit reads low and reads high for good once its fuse is opened.
// RULE5: the prom comes with open-collector or with three-state outputs.
// RULE6: fuses are opened one at a time, supply applied only after select is high.
// RULE7: current is gated through the fuse by raising select to the high level.
// RULE8: after the first pulse the supply is removed, the chip enabled, the bit read.
// RULE9: an unopened link gets further retry pulses, each verified afterwards.
// RULE10: once a link's total pulse time reaches the limit, programming is abandoned.
// RULE11: the same pulse and verify sequence is repeated for every bit to set.
// RULE12: past the cumulative heat limit all power is removed for the cool period.
// RULE13: after programming every word is read in sequence and checked.
// RULE14: every delay between programming edges exceeds the least spacing.
// RULE15: address and selected output stay fixed per bit, timed by clock counters.
`timescale 1ns/1ns
`include "fpp_regs.svh"

module fpp_ctrl #(
    parameter fpp_pkg::fpp_cnt_t T_FIRST_CYC    = `FPP_CW'(`FPP_FIRST_CYC),
    parameter fpp_pkg::fpp_cnt_t T_RETRY_CYC    = `FPP_CW'(`FPP_RETRY_CYC),
    parameter fpp_pkg::fpp_cnt_t T_LINK_MAX_CYC = `FPP_CW'(`FPP_LINK_MAX_CYC),
    parameter fpp_pkg::fpp_cnt_t T_HEAT_MAX_CYC = `FPP_CW'(`FPP_HEAT_MAX_CYC),
    parameter fpp_pkg::fpp_cnt_t T_COOL_CYC     = `FPP_CW'(`FPP_COOL_CYC)
) (
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    input  wire logic               start_read,
    input  wire logic               start_prog,
    input  wire logic               start_verify,
    input  wire fpp_pkg::fpp_addr_t cmd_addr,
    input  wire fpp_pkg::fpp_data_t cmd_mask,
    input  wire fpp_pkg::fpp_data_t vfy_expect,
    output logic                    busy,
    output logic                    done,
    output logic                    fail,
    output fpp_pkg::fpp_data_t      rd_data,
    output fpp_pkg::fpp_addr_t      vfy_addr,
    output logic                    vfy_err,
    output fpp_pkg::fpp_addr_t      err_addr,
    output fpp_pkg::fpp_addr_t      word_address,
    output logic                    cs_n,
    output logic                    cs_hv_en,
    output logic                    supply_en,
    output fpp_pkg::fpp_data_t      supply_sel,
    output logic                    vcc_en,
    input  wire fpp_pkg::fpp_data_t data_out
);
    localparam fpp_pkg::fpp_cnt_t EDGE_CYC = `FPP_CW'(`FPP_EDGE_CYC);
    localparam fpp_pkg::fpp_cnt_t ACC_CYC  = `FPP_CW'(`FPP_ACC_CYC);
    localparam fpp_pkg::fpp_addr_t LAST_ADDR = `FPP_AW'(`FPP_WORDS - 1);

    // --------------------------------------------------------------
    // reset release and pin sampling
    // --------------------------------------------------------------
    logic               rst_s1_q;
    logic               rst_n;
    fpp_pkg::fpp_data_t din_s1_q;
    fpp_pkg::fpp_data_t din_s2_q;
    fpp_pkg::fpp_data_t din_s3_q;
    fpp_pkg::fpp_data_t din_q;
    fpp_pkg::fpp_data_t din_d;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // a bit only changes once two later stages agree, so a glitch is ignored
    always_comb begin
        din_d = (din_s2_q & din_s3_q) | (din_q & (din_s2_q ^ din_s3_q));
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            din_s1_q <= 4'h0;
            din_s2_q <= 4'h0;
            din_s3_q <= 4'h0;
            din_q    <= 4'h0;
        end else begin
            din_s1_q <= data_out;
            din_s2_q <= din_s1_q;
            din_s3_q <= din_s2_q;
            din_q    <= din_d;
        end
    end

    // --------------------------------------------------------------
    // phase timer
    // --------------------------------------------------------------
    logic              tmr_load;
    fpp_pkg::fpp_cnt_t tmr_val;
    logic              tmr_done;

    fpp_timer u_timer (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .load     (tmr_load),
        .load_val (tmr_val),
        .expired  (tmr_done)
    );

    // highest set mask bit below index top, with a found flag on top
    function automatic logic [2:0] next_bit(input fpp_pkg::fpp_data_t mask,
                                            input logic [2:0] top);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < `FPP_DW; i++) begin
            if ((3'(i) < top) && mask[i]) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction

    // --------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------
    fpp_pkg::fpp_state_t state_q, state_d;
    fpp_pkg::fpp_addr_t  addr_q, addr_d;
    fpp_pkg::fpp_data_t  mask_q, mask_d;
    logic [1:0]          bit_q, bit_d;
    logic                first_q, first_d;
    fpp_pkg::fpp_cnt_t   link_q, link_d;
    fpp_pkg::fpp_cnt_t   heat_q, heat_d;
    fpp_pkg::fpp_data_t  rd_q, rd_d;
    logic                fail_q, fail_d;
    logic                verr_q, verr_d;
    fpp_pkg::fpp_addr_t  eaddr_q, eaddr_d;
    logic                done_q, done_d;
    logic                cs_n_q, cs_n_d;
    logic                hv_q, hv_d;
    logic                sup_q, sup_d;
    fpp_pkg::fpp_data_t  sel_q, sel_d;
    logic                vcc_q, vcc_d;
    logic [2:0]          nb;

    always_comb begin
        state_d  = state_q;
        addr_d   = addr_q;
        mask_d   = mask_q;
        bit_d    = bit_q;
        first_d  = first_q;
        link_d   = link_q;
        heat_d   = heat_q;
        rd_d     = rd_q;
        fail_d   = fail_q;
        verr_d   = verr_q;
        eaddr_d  = eaddr_q;
        done_d   = 1'b0;
        cs_n_d   = cs_n_q;
        hv_d     = hv_q;
        sup_d    = sup_q;
        sel_d    = sel_q;
        vcc_d    = vcc_q;
        tmr_load = 1'b0;
        tmr_val  = EDGE_CYC;
        nb       = 3'h0;
        case (state_q)
            fpp_pkg::FPP_IDLE: begin
                if (start_read) begin
                    // RULE2: select low to read
                    addr_d   = cmd_addr;
                    cs_n_d   = 1'b0;
                    fail_d   = 1'b0;
                    tmr_load = 1'b1;
                    tmr_val  = ACC_CYC;
                    state_d  = fpp_pkg::FPP_READ;
                end else if (start_verify) begin
                    addr_d   = '0;
                    cs_n_d   = 1'b0;
                    fail_d   = 1'b0;
                    verr_d   = 1'b0;
                    tmr_load = 1'b1;
                    tmr_val  = ACC_CYC;
                    state_d  = fpp_pkg::FPP_VERIFY;
                end else if (start_prog) begin
                    nb       = next_bit(cmd_mask, 3'h4);
                    addr_d   = cmd_addr;
                    mask_d   = cmd_mask;
                    fail_d   = 1'b0;
                    bit_d    = nb[1:0];
                    first_d  = 1'b1;
                    link_d   = '0;
                    tmr_load = 1'b1;
                    if (nb[2]) begin
                        state_d = fpp_pkg::FPP_SETUP;
                    end else begin
                        done_d  = 1'b1;
                    end
                end
            end
            fpp_pkg::FPP_READ: begin
                if (tmr_done) begin
                    // RULE3: release select, outputs float
                    rd_d    = din_q;
                    cs_n_d  = 1'b1;
                    done_d  = 1'b1;
                    state_d = fpp_pkg::FPP_IDLE;
                end
            end
            fpp_pkg::FPP_VERIFY: begin
                if (tmr_done) begin
                    // RULE13: sequential word check
                    if ((din_q != vfy_expect) && !verr_q) begin
                        verr_d  = 1'b1;
                        eaddr_d = addr_q;
                    end
                    tmr_load = 1'b1;
                    tmr_val  = ACC_CYC;
                    if (addr_q == LAST_ADDR) begin
                        cs_n_d  = 1'b1;
                        fail_d  = verr_d;
                        done_d  = 1'b1;
                        state_d = fpp_pkg::FPP_IDLE;
                    end else begin
                        addr_d  = addr_q + 1'b1;
                    end
                end
            end
            fpp_pkg::FPP_SETUP: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    if (heat_q >= T_HEAT_MAX_CYC) begin
                        // RULE12: power off to cool
                        vcc_d   = 1'b0;
                        tmr_val = T_COOL_CYC;
                        state_d = fpp_pkg::FPP_COOL;
                    end else begin
                        // RULE6: supply only after select high
                        sup_d   = 1'b1;
                        sel_d   = 4'h1 << bit_q;
                        state_d = fpp_pkg::FPP_SUPPLY;
                    end
                end
            end
            fpp_pkg::FPP_SUPPLY: begin
                if (tmr_done) begin
                    // RULE7: gate the fuse current
                    hv_d     = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val  = first_q ? T_FIRST_CYC : T_RETRY_CYC;
                    state_d  = fpp_pkg::FPP_GATE;
                end
            end
            fpp_pkg::FPP_GATE: begin
                // RULE10: per-link pulse total
                link_d = link_q + 1'b1;
                heat_d = heat_q + 1'b1;
                if (tmr_done) begin
                    hv_d     = 1'b0;
                    tmr_load = 1'b1;
                    state_d  = fpp_pkg::FPP_UNGATE;
                end
            end
            fpp_pkg::FPP_UNGATE: begin
                if (tmr_done) begin
                    // RULE8: remove supply before sensing
                    sup_d    = 1'b0;
                    tmr_load = 1'b1;
                    state_d  = fpp_pkg::FPP_UNSUPPLY;
                end
            end
            fpp_pkg::FPP_UNSUPPLY: begin
                if (tmr_done) begin
                    cs_n_d   = 1'b0;
                    first_d  = 1'b0;
                    tmr_load = 1'b1;
                    state_d  = fpp_pkg::FPP_SENSE;
                end
            end
            fpp_pkg::FPP_SENSE: begin
                if (tmr_done) begin
                    // RULE14: select and supply edges spaced by the edge delay; the gate pulse by its own count
                    cs_n_d   = 1'b1;
                    tmr_load = 1'b1;
                    nb       = next_bit(mask_q, {1'b0, bit_q});
                    if (din_q[bit_q]) begin
                        // RULE11: move on to the next bit
                        if (nb[2]) begin
                            bit_d   = nb[1:0];
                            link_d  = '0;
                            first_d = 1'b1;
                            state_d = fpp_pkg::FPP_SETUP;
                        end else begin
                            done_d  = 1'b1;
                            state_d = fpp_pkg::FPP_IDLE;
                        end
                    end else if (link_q >= T_LINK_MAX_CYC) begin
                        // RULE10: give up on this device
                        fail_d  = 1'b1;
                        done_d  = 1'b1;
                        state_d = fpp_pkg::FPP_IDLE;
                    end else begin
                        // RULE9: retry with a longer pulse
                        state_d = fpp_pkg::FPP_SETUP;
                    end
                end
            end
            fpp_pkg::FPP_COOL: begin
                if (tmr_done) begin
                    vcc_d    = 1'b1;
                    heat_d   = '0;
                    tmr_load = 1'b1;
                    state_d  = fpp_pkg::FPP_SETUP;
                end
            end
            default: begin
                state_d = fpp_pkg::FPP_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= fpp_pkg::FPP_IDLE;
            addr_q  <= 11'h000;
            mask_q  <= 4'h0;
            bit_q   <= 2'h0;
            first_q <= 1'b0;
            link_q  <= '0;
            heat_q  <= '0;
            rd_q    <= 4'h0;
            fail_q  <= 1'b0;
            verr_q  <= 1'b0;
            eaddr_q <= 11'h000;
            done_q  <= 1'b0;
            cs_n_q  <= 1'b1;
            hv_q    <= 1'b0;
            sup_q   <= 1'b0;
            sel_q   <= 4'h0;
            vcc_q   <= 1'b1;
        end else begin
            state_q <= state_d;
            addr_q  <= addr_d;
            mask_q  <= mask_d;
            bit_q   <= bit_d;
            first_q <= first_d;
            link_q  <= link_d;
            heat_q  <= heat_d;
            rd_q    <= rd_d;
            fail_q  <= fail_d;
            verr_q  <= verr_d;
            eaddr_q <= eaddr_d;
            done_q  <= done_d;
            cs_n_q  <= cs_n_d;
            hv_q    <= hv_d;
            sup_q   <= sup_d;
            sel_q   <= sel_d;
            vcc_q   <= vcc_d;
        end
    end

    // RULE15: address held in a register for the whole bit
    assign word_address = addr_q;
    assign vfy_addr     = addr_q;
    assign busy         = (state_q != fpp_pkg::FPP_IDLE);
    assign done         = done_q;
    assign fail         = fail_q;
    assign rd_data      = rd_q;
    assign vfy_err      = verr_q;
    assign err_addr     = eaddr_q;
    assign cs_n         = cs_n_q;
    assign cs_hv_en     = hv_q;
    assign supply_en    = sup_q;
    assign supply_sel   = sel_q;
    assign vcc_en       = vcc_q;
endmodule

// File: logic/fpp_regs.svh
// timing counts, widths and sizes for the fuse prom programmer
// assumes a 100 MHz ref_clk; included by the package and the modules
`ifndef FPP_REGS_SVH
`define FPP_REGS_SVH

`define FPP_AW            11
`define FPP_DW            4
`define FPP_CW            29
`define FPP_WORDS         2048
`define FPP_CLK_MHZ       100
`define FPP_SYNC_CYC      3

`define FPP_T_FIRST_US    50
`define FPP_T_RETRY_MS    5
`define FPP_T_LINK_MAX_MS 400
`define FPP_T_HEAT_MAX_S  5
`define FPP_T_COOL_S      5
`define FPP_T_EDGE_NS     500
`define FPP_T_ACC_NS      100

`define FPP_NS2CYC_UP(ns) ((((ns) * `FPP_CLK_MHZ) + 999) / 1000)
`define FPP_EDGE_CYC      `FPP_NS2CYC_UP(`FPP_T_EDGE_NS)
`define FPP_ACC_CYC       (`FPP_NS2CYC_UP(`FPP_T_ACC_NS) + `FPP_SYNC_CYC)
`define FPP_FIRST_CYC     (`FPP_T_FIRST_US * `FPP_CLK_MHZ)
`define FPP_RETRY_CYC     (`FPP_T_RETRY_MS * 1000 * `FPP_CLK_MHZ)
`define FPP_LINK_MAX_CYC  (`FPP_T_LINK_MAX_MS * 1000 * `FPP_CLK_MHZ)
`define FPP_HEAT_MAX_CYC  (`FPP_T_HEAT_MAX_S * 1000000 * `FPP_CLK_MHZ)
`define FPP_COOL_CYC      (`FPP_T_COOL_S * 1000000 * `FPP_CLK_MHZ)

`endif

// File: logic/fpp_pkg.sv
// types shared by the fuse prom programmer
// assumes fpp_regs.svh for widths
`include "fpp_regs.svh"

package fpp_pkg;
    typedef logic [`FPP_AW-1:0] fpp_addr_t;
    typedef logic [`FPP_DW-1:0] fpp_data_t;
    typedef logic [`FPP_CW-1:0] fpp_cnt_t;

    typedef enum logic [3:0] {
        FPP_IDLE,
        FPP_READ,
        FPP_VERIFY,
        FPP_SETUP,
        FPP_SUPPLY,
        FPP_GATE,
        FPP_UNGATE,
        FPP_UNSUPPLY,
        FPP_SENSE,
        FPP_COOL
    } fpp_state_t;
endpackage

// File: logic/fpp_timer.sv
// down counter used for every timed phase of the programmer
// assumes a synchronised active-low reset from the top
`timescale 1ns/1ns
`include "fpp_regs.svh"

module fpp_timer (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire fpp_pkg::fpp_cnt_t load_val,
    output logic                  expired
);
    fpp_pkg::fpp_cnt_t cnt_q;
    fpp_pkg::fpp_cnt_t cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = load_val;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign expired = (cnt_q == '0);
endmodule

// File: sim/fpp_prom_model.sv
// behavioural 2048 x 4 fuse prom facing the programmer's pins
// assumes ref_clk to time fuse heating and step the floating pattern; need_cyc and stuck come from the bench
`timescale 1ns/1ns
module fpp_prom_model (
    input  wire logic               open_coll,
    input  wire logic               ref_clk,
    input  wire fpp_pkg::fpp_addr_t word_address,
    input  wire logic               cs_n,
    input  wire logic               cs_hv_en,
    input  wire logic               supply_en,
    input  wire fpp_pkg::fpp_data_t supply_sel,
    input  wire logic               vcc_en,
    input  wire logic [15:0]        need_cyc,
    input  wire logic               stuck,
    output fpp_pkg::fpp_data_t      data_out
);
    fpp_pkg::fpp_data_t mem [2048];
    fpp_pkg::fpp_data_t flt_q  = 4'h5;
    logic [15:0]        heat_q = 16'h0000;
    initial foreach (mem[i]) mem[i] = 4'h0;
    // a link opens for good once enough gated current has flowed
    always @(posedge ref_clk) begin
        flt_q <= ~flt_q;
        if (stuck) begin
            heat_q <= 16'h0000;
        end else if (cs_hv_en && supply_en && cs_n && vcc_en) begin
            heat_q <= heat_q + 16'h0001;
            if (heat_q + 16'h0001 >= need_cyc) begin
                mem[word_address] <= mem[word_address] | supply_sel;
                heat_q <= 16'h0000;
            end
        end
    end
    // disabled outputs float: pulled up, or a moving pattern
    assign data_out = (!cs_n && vcc_en) ? mem[word_address] : (open_coll ? 4'hf : flt_q);
endmodule

// File: sim/fpp_ctrl_monitor.sv
// concurrent checks on the programmer's prom pins and read start
// assumes binding into fpp_ctrl; pulse counts are that instance's parameters
`timescale 1ns/1ns
module fpp_ctrl_monitor #(
    parameter fpp_pkg::fpp_cnt_t T_FIRST_CYC = 29'h000_0014,
    parameter fpp_pkg::fpp_cnt_t T_RETRY_CYC = 29'h000_0032,
    parameter fpp_pkg::fpp_cnt_t T_COOL_CYC  = 29'h000_001e
) (
    input wire logic               ref_clk,
    input wire logic               rstn,
    input wire logic               start_read,
    input wire logic               busy,
    input wire fpp_pkg::fpp_addr_t cmd_addr,
    input wire fpp_pkg::fpp_addr_t word_address,
    input wire logic               cs_n,
    input wire logic               cs_hv_en,
    input wire logic               supply_en,
    input wire fpp_pkg::fpp_data_t supply_sel,
    input wire logic               vcc_en
);
    // ------------------------------------------------------------
    // pulse and power-off length counters
    // ------------------------------------------------------------
    fpp_pkg::fpp_cnt_t gate_q, gate_d, off_q, off_d;
    always_comb begin
        gate_d = cs_hv_en ? gate_q + 29'h000_0001 : 29'h000_0000;
        off_d  = vcc_en ? 29'h000_0000 : off_q + 29'h000_0001;
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            gate_q <= 29'h000_0000;
            off_q  <= 29'h000_0000;
        end else begin
            gate_q <= gate_d;
            off_q  <= off_d;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_supply_one; supply_en |-> cs_n && $onehot(supply_sel); endproperty
    a_supply_one: assert property (p_supply_one) else $error("supply bad select");
    property p_gate_path; cs_hv_en |-> supply_en && cs_n && vcc_en; endproperty
    a_gate_path: assert property (p_gate_path) else $error("gate without supply");
    property p_gate_setup; $rose(cs_hv_en) |-> $past(supply_en, 50); endproperty
    a_gate_setup: assert property (p_gate_setup) else $error("gate too soon");
    property p_pulse_min; $fell(cs_hv_en) |-> gate_q >= T_FIRST_CYC; endproperty
    a_pulse_min: assert property (p_pulse_min) else $error("pulse too short");
    property p_pulse_max; $fell(cs_hv_en) |-> gate_q <= T_RETRY_CYC + 2; endproperty
    a_pulse_max: assert property (p_pulse_max) else $error("pulse too long");
    property p_gate_hold; $fell(cs_hv_en) |-> (supply_en && cs_n) [*8]; endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("supply dropped early");
    property p_sense; $fell(supply_en) |-> cs_n ##[45:55] !cs_n; endproperty
    a_sense: assert property (p_sense) else $error("no sense after pulse");
    property p_hold; supply_en && $past(supply_en) |-> $stable(word_address) && $stable(supply_sel);
    endproperty
    a_hold: assert property (p_hold) else $error("address moved in pulse");
    property p_cool_off; !vcc_en |-> !supply_en && !cs_hv_en; endproperty
    a_cool_off: assert property (p_cool_off) else $error("drive while unpowered");
    property p_cool_len; $rose(vcc_en) |-> off_q >= T_COOL_CYC; endproperty
    a_cool_len: assert property (p_cool_len) else $error("cool period short");
    property p_read_addr; start_read && !busy |=> !cs_n && word_address == $past(cmd_addr);
    endproperty
    a_read_addr: assert property (p_read_addr) else $error("read address wrong");
    c_read: cover property (start_read && !busy);
    c_pulse: cover property ($fell(cs_hv_en));
    c_cool: cover property ($rose(vcc_en));
endmodule

bind fpp_ctrl fpp_ctrl_monitor #(
    .T_FIRST_CYC(T_FIRST_CYC),
    .T_RETRY_CYC(T_RETRY_CYC),
    .T_COOL_CYC (T_COOL_CYC)
) u_fpp_ctrl_monitor (
    .ref_clk     (ref_clk),
    .rstn        (rstn),
    .start_read  (start_read),
    .busy        (busy),
    .cmd_addr    (cmd_addr),
    .word_address(word_address),
    .cs_n        (cs_n),
    .cs_hv_en    (cs_hv_en),
    .supply_en   (supply_en),
    .supply_sel  (supply_sel),
    .vcc_en      (vcc_en)
);

// File: sim/fpp_ctrl_tb.sv
// self-checking bench: drives read, program and verify commands at the programmer
// assumes fpp_prom_model on the prom pins and the checker bound by its own file
`timescale 1ns/1ns
module fpp_ctrl_tb;
    typedef struct { logic [1:0] kind; logic [10:0] val; logic fl; } fpp_note_t;
    logic               ref_clk = 1'b0;
    logic               rstn = 1'b0;
    logic               start_read = 1'b0, start_prog = 1'b0, start_verify = 1'b0;
    fpp_pkg::fpp_addr_t cmd_addr = 11'h000;
    fpp_pkg::fpp_data_t cmd_mask = 4'h0;
    logic [15:0]        need_cyc = 16'h0001;
    logic               stuck = 1'b0, oc = 1'b0;
    logic               busy, done, fail, vfy_err, cs_n, cs_hv_en, supply_en, vcc_en;
    fpp_pkg::fpp_data_t rd_data, supply_sel, data_out, vfy_expect;
    fpp_pkg::fpp_addr_t vfy_addr, err_addr, word_address;
    fpp_pkg::fpp_data_t shadow [2048];
    fpp_note_t          notes [$];
    fpp_note_t          n;
    int                 num_errors = 0;
    int                 cmp_count = 0;
    initial foreach (shadow[i]) shadow[i] = 4'h0;
    assign vfy_expect = shadow[vfy_addr];
    initial forever #5 ref_clk = ~ref_clk;
    // short counts keep the run small; expectations follow these values
    fpp_ctrl #(.T_FIRST_CYC(29'h000_0014), .T_RETRY_CYC(29'h000_0032),
        .T_LINK_MAX_CYC(29'h000_00c8), .T_HEAT_MAX_CYC(29'h000_00fa),
        .T_COOL_CYC(29'h000_001e)) u_fpp_ctrl (.ref_clk(ref_clk), .rstn(rstn),
        .start_read(start_read), .start_prog(start_prog), .start_verify(start_verify),
        .cmd_addr(cmd_addr), .cmd_mask(cmd_mask), .vfy_expect(vfy_expect), .busy(busy),
        .done(done), .fail(fail), .rd_data(rd_data), .vfy_addr(vfy_addr),
        .vfy_err(vfy_err), .err_addr(err_addr), .word_address(word_address), .cs_n(cs_n),
        .cs_hv_en(cs_hv_en), .supply_en(supply_en), .supply_sel(supply_sel),
        .vcc_en(vcc_en), .data_out(data_out));
    fpp_prom_model u_fpp_prom_model (.ref_clk(ref_clk), .open_coll(oc),
        .word_address(word_address), .cs_n(cs_n), .cs_hv_en(cs_hv_en),
        .supply_en(supply_en), .supply_sel(supply_sel), .vcc_en(vcc_en),
        .need_cyc(need_cyc), .stuck(stuck), .data_out(data_out));
    task automatic check(input string what, input logic [10:0] got, input logic [10:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // one command; the expected outcome is queued before it starts
    task automatic run(input logic [1:0] kind, input logic [10:0] a, input logic [3:0] m,
                       input logic [10:0] ev, input logic ef, input int lim);
        notes.push_back('{kind, ev, ef});
        @(posedge ref_clk);
        #1;
        cmd_addr = a;
        cmd_mask = m;
        {start_read, start_prog, start_verify} = {kind == 2'd0, kind == 2'd1, kind == 2'd2};
        @(posedge ref_clk);
        #1;
        {start_read, start_prog, start_verify} = 3'b000;
        for (int i = 0; i < lim; i++) begin
            @(negedge ref_clk);
            if (done === 1'b1) return;
        end
        check("done", 11'h000, 11'h001);
        close_out();
    endtask
    // results are taken as done shows; an unasked done is a mismatch
    always @(negedge ref_clk) begin
        if (done === 1'b1) begin
            if (notes.size() == 0) begin
                check("unasked done", 11'h001, 11'h000);
            end else begin
                n = notes.pop_front();
                check("fail", 11'(fail), 11'(n.fl));
                if (n.kind == 2'd0) check("rd_data", 11'(rd_data), n.val);
                if (n.kind == 2'd2) check("vfy_err", 11'(vfy_err), 11'(n.fl));
                if (n.kind == 2'd2 && n.fl) check("err_addr", err_addr, n.val);
            end
        end
    end
    initial begin
        fpp_pkg::fpp_addr_t a;
        fpp_pkg::fpp_data_t m;
        void'($urandom(32'h808a));
        repeat (20) @(posedge ref_clk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 11'h000 : (i == 1) ? 11'h7ff : 11'($urandom);
            run(2'd0, a, 4'h0, 11'h000, 1'b0, 100);
        end
        $display("test blank_read done");
        // first-pulse links, retried links, empty mask
        for (int j = 0; j < 3; j++) begin
            a = 11'($urandom);
            m = (j == 2) ? 4'h0 : 4'($urandom) | 4'h1;
            need_cyc = (j == 1) ? 16'h0028 : 16'h0001;
            oc = 1'($urandom);
            run(2'd1, a, m, 11'h000, 1'b0, 20000);
            shadow[a] = shadow[a] | m;
            run(2'd0, a, 4'h0, 11'(shadow[a]), 1'b0, 100);
        end
        $display("test program done");
        // link never opens; a read start while busy is ignored
        stuck = 1'b1;
        a = 11'($urandom);
        fork
            run(2'd1, a, 4'h1, 11'h000, 1'b1, 20000);
            begin
                repeat (100) @(posedge ref_clk);
                #1 start_read = 1'b1;
                @(posedge ref_clk);
                #1 start_read = 1'b0;
            end
        join
        stuck = 1'b0;
        run(2'd0, a, 4'h0, 11'(shadow[a]), 1'b0, 100);
        $display("test give_up done");
        // full sweep clean, then with one expected word altered
        run(2'd2, 11'h000, 4'h0, 11'h000, 1'b0, 40000);
        a = 11'($urandom);
        shadow[a] = shadow[a] ^ 4'h8;
        run(2'd2, 11'h000, 4'h0, a, 1'b1, 40000);
        $display("test verify done");
        repeat (5) @(posedge ref_clk);
        check("notes left", 11'(notes.size()), 11'h000);
        close_out();
    end
endmodule
